/* rtl/srx_pkg.sv */
// package: register map, field layout and types of the receive mode control block
package srx_pkg;
    // ---------------------------------------------------------------
    // register word offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_FLAGS   = 8'h04;
    localparam logic [7:0] OFS_SYMWIN  = 8'h08;
    localparam logic [7:0] OFS_TMO     = 8'h0c;
    localparam logic [7:0] OFS_PRELEN  = 8'h10;
    localparam logic [7:0] OFS_PTR     = 8'h14;
    localparam logic [7:0] OFS_DATA    = 8'h18;
    localparam logic [7:0] OFS_RXBASE  = 8'h1c;
    localparam logic [7:0] OFS_PKTSTRT = 8'h20;
    localparam logic [7:0] OFS_NBYTES  = 8'h24;
    localparam logic [7:0] OFS_WRPOS   = 8'h28;
    // ---------------------------------------------------------------
    // event flag bit positions
    // ---------------------------------------------------------------
    localparam int FLG_TIMEOUT = 0;
    localparam int FLG_PACKET_RECEIVED_FLAG  = 1;
    localparam int FLG_CRCFAIL = 2;
    localparam int FLG_HEADER  = 3;
    localparam int FLG_W       = 4;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [9:0]  RST_SYMWIN = 10'h005;
    localparam logic [15:0] RST_TMO    = 16'h0000;
    localparam logic [15:0] RST_PRELEN = 16'h0008;
    localparam logic [7:0]  RST_RXBASE = 8'h00;
    localparam int          BUF_DEPTH  = 256;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_SLEEP, MODE_STANDBY, MODE_SYNTH_TX, MODE_TX,
        MODE_SYNTH_RX, MODE_RX_CONT, MODE_RX_SINGLE, MODE_CAD
    } srx_mode_e;
    typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_PREAMBLE, ST_PAYLOAD} srx_state_e;
    // demodulator events into the block
    typedef struct packed {
        logic       sym_tick;
        logic       preamble_start;
        logic       preamble_sync;
        logic       header_ok;
        logic       byte_valid;
        logic [7:0] byte_data;
        logic       payload_done;
        logic       crc_bad;
    } srx_evt_s;
endpackage

/* rtl/srx_rx_ctrl.sv */
// receive mode control: rx modes, search window, timeout, flags, data buffer, wishbone registers
// Function
// RULE1 - one-shot: no preamble within search window sets timeout flag, back to standby
// RULE2 - search window counted in symbols, legal 4..1023, resets to 5
// RULE3 - payload end sets packet flag; check failure also sets check-fail flag same cycle
// RULE4 - payload bytes are stored even when the payload check fails
// RULE5 - one-shot: packet or timeout flag returns device to standby
// RULE6 - host writes static configuration only in sleep, standby or rx synth mode
// RULE7 - wait for preamble, then freeze gain; valid header sets header flag
// RULE8 - host resets access pointer to rx base before reselecting one-shot mode
// RULE9 - continuous: keep searching, track each packet, resume search, stay in mode
// RULE10 - continuous: overlong preamble dropped silently and search restarted
// RULE11 - continuous: timeout sets flag, mode kept; host clears the flag
// RULE12 - continuous: packets written back to back, write pointer never reset
// RULE13 - host selects continuous mode only from sleep or standby
// RULE14 - continuous: status kept for latest packet only, overwritten by next
// RULE15 - report received byte count and start location of latest packet
// RULE16 - host loads pointer from packet start and reads data port count times
// RULE17 - write position register shows one past last byte written, live
// RULE18 - header flag raised in implicit as well as explicit header mode
// RULE19 - absolute timer starts on rx entry, lasts timeout value times symbol period
// RULE20 - host clears timeout flag before reselecting one-shot mode
// RULE21 - host checks flags before extraction and discards errored packets
// RULE22 - each data port read or write advances the access pointer by one; code skips the step in sleep mode and for writes without wb_sel_i[0]
// RULE23 - rx base address resets to 0x00
// RULE24 - event flags stay set until cleared by host through the flag register
`timescale 1ns/1ps
`default_nettype none
module srx_rx_ctrl
    import srx_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire srx_evt_s    evt,
    output logic             gain_freeze,
    output logic             rx_active,
    output logic      [2:0]  mode_out
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    srx_mode_e          mode_q, mode_d;
    srx_state_e         st_q, st_d;
    logic [FLG_W-1:0]   flags_q, flags_d;
    logic [9:0]         symwin_q, symwin_d;
    logic [15:0]        tmo_q, tmo_d;
    logic [15:0]        prelen_q, prelen_d;
    logic [7:0]         ptr_q, ptr_d;
    logic [7:0]         rxbase_q, rxbase_d;
    logic [7:0]         pktstrt_q, pktstrt_d;
    logic [7:0]         nbytes_q, nbytes_d;
    logic [7:0]         wrpos_q, wrpos_d;
    logic [9:0]         wincnt_q, wincnt_d;
    logic [15:0]        abscnt_q, abscnt_d;
    logic               absdone_q, absdone_d;
    logic [15:0]        precnt_q, precnt_d;
    logic               ack_q, ack_d;
    logic [31:0]        rdat_q, rdat_d;
    logic [7:0]         mem [BUF_DEPTH];

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic       req;
    logic       wr;
    logic       rd;
    logic       data_acc;
    logic       in_rx;
    logic       rx_entry;
    logic       host_buf_wr;
    logic       modem_wr;
    logic       win_exp;
    logic       abs_exp;
    logic       pkt_end;

    // one request per ack, ack one cycle after the request is seen
    assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr       = req & wb_we_i & wb_sel_i[0];
    assign rd       = req & ~wb_we_i;
    // buffer unreachable in sleep
    assign data_acc = (wr | rd) & (wb_adr_i == OFS_DATA) & (mode_q != MODE_SLEEP);
    assign in_rx    = (mode_q == MODE_RX_SINGLE) | (mode_q == MODE_RX_CONT);
    assign host_buf_wr = data_acc & wr;
    // modem bytes land while a payload is tracked, whatever the check result
    assign modem_wr = in_rx & (st_q == ST_PAYLOAD) & evt.byte_valid; // RULE4
    assign pkt_end  = in_rx & (st_q == ST_PAYLOAD) & evt.payload_done;
    assign win_exp  = (mode_q == MODE_RX_SINGLE) & (st_q == ST_SEARCH) & evt.sym_tick
                      & (wincnt_q + 10'h001 >= symwin_q); // RULE1 RULE2
    assign abs_exp  = in_rx & ~absdone_q & (tmo_q != 16'h0000) & evt.sym_tick
                      & (abscnt_q + 16'h0001 >= tmo_q); // RULE19

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb
    begin
        mode_d    = mode_q;
        st_d      = st_q;
        flags_d   = flags_q;
        symwin_d  = symwin_q;
        tmo_d     = tmo_q;
        prelen_d  = prelen_q;
        ptr_d     = ptr_q;
        rxbase_d  = rxbase_q;
        pktstrt_d = pktstrt_q;
        nbytes_d  = nbytes_q;
        wrpos_d   = wrpos_q;
        wincnt_d  = wincnt_q;
        abscnt_d  = abscnt_q;
        absdone_d = absdone_q;
        precnt_d  = precnt_q;
        rx_entry  = 1'b0;
        ack_d     = req;
        rdat_d    = 32'h0000_0000;

        // receive sequencing
        if (in_rx)
        begin
            if (evt.sym_tick)
                abscnt_d = abscnt_q + 16'h0001; // RULE19
            if (abs_exp)
                absdone_d = 1'b1;
            case (st_q)
                ST_SEARCH:
                begin
                    if (evt.sym_tick)
                        wincnt_d = wincnt_q + 10'h001;
                    if (evt.preamble_start)
                    begin
                        st_d     = ST_PREAMBLE;
                        precnt_d = 16'h0000;
                    end
                end
                ST_PREAMBLE:
                begin
                    if (evt.preamble_sync)
                    begin
                        // gain fixed from here; new packet starts at current write spot
                        st_d      = ST_PAYLOAD; // RULE7
                        pktstrt_d = wrpos_q; // RULE12 RULE14 RULE15
                        nbytes_d  = 8'h00;
                    end
                    else if (evt.sym_tick)
                    begin
                        precnt_d = precnt_q + 16'h0001;
                        if ((mode_q == MODE_RX_CONT) && (precnt_q + 16'h0001 > prelen_q))
                            st_d = ST_SEARCH; // RULE10
                    end
                end
                ST_PAYLOAD:
                begin
                    if (modem_wr)
                    begin
                        wrpos_d  = wrpos_q + 8'h01; // RULE17
                        nbytes_d = nbytes_q + 8'h01; // RULE15
                    end
                    if (evt.payload_done)
                        st_d = ST_SEARCH; // RULE9
                end
                default: st_d = ST_SEARCH;
            endcase
            // one-shot ends on packet, expired window or expired absolute timer
            if ((mode_q == MODE_RX_SINGLE) && (pkt_end || win_exp || abs_exp))
            begin
                mode_d = MODE_STANDBY; // RULE1 RULE5
                st_d   = ST_IDLE;
            end
        end
        else
            st_d = ST_IDLE;

        // register writes; software mode change overrides hardware fallback
        if (wr)
        begin
            case (wb_adr_i)
                OFS_MODE:
                begin
                    mode_d = srx_mode_e'(wb_dat_i[2:0]);
                    if ((wb_dat_i[2:0] != 3'(mode_q))
                        && ((wb_dat_i[2:0] == 3'(MODE_RX_SINGLE)) || (wb_dat_i[2:0] == 3'(MODE_RX_CONT))))
                    begin
                        rx_entry = 1'b1;
                    end
                end
                OFS_FLAGS:  flags_d  = flags_q & ~wb_dat_i[FLG_W-1:0]; // RULE24
                OFS_SYMWIN: symwin_d = wb_dat_i[9:0]; // RULE2
                OFS_TMO:    tmo_d    = wb_dat_i[15:0];
                OFS_PRELEN: prelen_d = wb_dat_i[15:0];
                OFS_PTR:    ptr_d    = wb_dat_i[7:0];
                OFS_RXBASE: rxbase_d = wb_dat_i[7:0];
                default:    ;
            endcase
        end

        // entry into a receive mode restarts timers and the search
        if (rx_entry)
        begin
            st_d      = ST_SEARCH; // RULE7
            wincnt_d  = 10'h000;
            abscnt_d  = 16'h0000; // RULE19
            absdone_d = 1'b0;
            wrpos_d   = rxbase_q; // RULE12
        end

        // data port access steps the pointer
        if (data_acc)
            ptr_d = ptr_q + 8'h01; // RULE22

        // hardware sets win over a same-cycle clear
        if (win_exp || abs_exp)
            flags_d[FLG_TIMEOUT] = 1'b1; // RULE1 RULE11
        // header accepted in preamble or payload, implicit and explicit alike
        if (in_rx && ((st_q == ST_PREAMBLE) || (st_q == ST_PAYLOAD)) && evt.header_ok)
            flags_d[FLG_HEADER] = 1'b1; // RULE7 RULE18
        if (pkt_end)
        begin
            flags_d[FLG_PACKET_RECEIVED_FLAG] = 1'b1; // RULE3
            if (evt.crc_bad)
                flags_d[FLG_CRCFAIL] = 1'b1; // RULE3
        end

        // read data mux, unmapped reads give zero
        if (rd)
        begin
            case (wb_adr_i)
                OFS_MODE:    rdat_d = {29'h0, 3'(mode_q)};
                OFS_FLAGS:   rdat_d = {28'h0, flags_q};
                OFS_SYMWIN:  rdat_d = {22'h0, symwin_q};
                OFS_TMO:     rdat_d = {16'h0, tmo_q};
                OFS_PRELEN:  rdat_d = {16'h0, prelen_q};
                OFS_PTR:     rdat_d = {24'h0, ptr_q};
                OFS_DATA:    rdat_d = (mode_q == MODE_SLEEP) ? 32'h0 : {24'h0, mem[ptr_q]};
                OFS_RXBASE:  rdat_d = {24'h0, rxbase_q};
                OFS_PKTSTRT: rdat_d = {24'h0, pktstrt_q}; // RULE15
                OFS_NBYTES:  rdat_d = {24'h0, nbytes_q}; // RULE15
                OFS_WRPOS:   rdat_d = {24'h0, wrpos_q}; // RULE17
                default:     rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q    <= MODE_STANDBY;
            st_q      <= ST_IDLE;
            flags_q   <= '0;
            symwin_q  <= RST_SYMWIN; // RULE2
            tmo_q     <= RST_TMO;
            prelen_q  <= RST_PRELEN;
            ptr_q     <= 8'h00;
            rxbase_q  <= RST_RXBASE; // RULE23
            pktstrt_q <= 8'h00;
            nbytes_q  <= 8'h00;
            wrpos_q   <= 8'h00;
            wincnt_q  <= 10'h000;
            abscnt_q  <= 16'h0000;
            absdone_q <= 1'b0;
            precnt_q  <= 16'h0000;
            ack_q     <= 1'b0;
            rdat_q    <= 32'h0000_0000;
        end
        else
        begin
            mode_q    <= mode_d;
            st_q      <= st_d;
            flags_q   <= flags_d;
            symwin_q  <= symwin_d;
            tmo_q     <= tmo_d;
            prelen_q  <= prelen_d;
            ptr_q     <= ptr_d;
            rxbase_q  <= rxbase_d;
            pktstrt_q <= pktstrt_d;
            nbytes_q  <= nbytes_d;
            wrpos_q   <= wrpos_d;
            wincnt_q  <= wincnt_d;
            abscnt_q  <= abscnt_d;
            absdone_q <= absdone_d;
            precnt_q  <= precnt_d;
            ack_q     <= ack_d;
            rdat_q    <= rdat_d;
        end
    end

    // ---------------------------------------------------------------
    // data buffer: cleared in sleep, modem write wins an address clash
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (mode_q == MODE_SLEEP)
        begin
            for (int i = 0; i < BUF_DEPTH; i++)
            begin
                mem[i] <= 8'h00;
            end
        end
        else
        begin
            if (host_buf_wr)
            begin
                mem[ptr_q] <= wb_dat_i[7:0];
            end
            if (modem_wr)
            begin
                mem[wrpos_q] <= evt.byte_data; // RULE4 RULE12
            end
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = rdat_q;
    assign gain_freeze = (st_q == ST_PAYLOAD) & in_rx; // RULE7 no lock once host leaves rx
    assign rx_active   = in_rx;
    assign mode_out    = 3'(mode_q);
endmodule // srx_rx_ctrl
`default_nettype wire

/* sim/srx_rx_chk.sv */
// checker: concurrent assertions on the receive mode control ports
`timescale 1ns/1ps
`default_nettype none
module srx_rx_chk
    import srx_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire srx_evt_s    evt,
    input wire logic        gain_freeze,
    input wire logic        rx_active,
    input wire logic [2:0]  mode_out
);
    // request taken this edge, and host writes of the mode register
    logic take;
    logic mwr;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign mwr  = take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_MODE;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ---------------------------------------------------------------
    // sequences and properties
    // ---------------------------------------------------------------
    sequence s_req; take; endsequence
    sequence s_end; gain_freeze && evt.payload_done && !mwr; endsequence
    property p_ack; s_req |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_single_end; (mode_out == MODE_RX_SINGLE) ##0 s_end |=> mode_out == MODE_STANDBY; endproperty
    property p_cont_end; (mode_out == MODE_RX_CONT) ##0 s_end |=> mode_out == MODE_RX_CONT && !gain_freeze;
    endproperty
    property p_single_exit;
        (mode_out == MODE_RX_SINGLE && !mwr) ##1 (mode_out == MODE_STANDBY)
            |-> $past(evt.sym_tick) || $past(evt.payload_done);
    endproperty
    property p_cont_stay; mode_out == MODE_RX_CONT && !mwr |=> mode_out == MODE_RX_CONT; endproperty
    property p_gain_rise; $rose(gain_freeze) |-> $past(evt.preamble_sync); endproperty
    property p_gain_rx; gain_freeze |-> rx_active; endproperty
    property p_mode_hold; !rx_active && !mwr |=> $stable(mode_out); endproperty
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_ack: assert property (p_ack) else $error("no ack after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_single_end: assert property (p_single_end) else $error("one-shot packet end kept rx");
    a_cont_end: assert property (p_cont_end) else $error("continuous packet end left mode");
    a_single_exit: assert property (p_single_exit) else $error("one-shot exit without cause");
    a_cont_stay: assert property (p_cont_stay) else $error("continuous mode left by itself");
    a_gain_rise: assert property (p_gain_rise) else $error("gain locked without preamble");
    a_gain_rx: assert property (p_gain_rx) else $error("gain locked outside rx");
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed without host write");
endmodule // srx_rx_chk
bind srx_rx_ctrl srx_rx_chk srx_rx_chk_i (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .evt(evt), .gain_freeze(gain_freeze), .rx_active(rx_active), .mode_out(mode_out)
);
`default_nettype wire

/* sim/srx_modem_model.sv */
// modem event source standing in for the demodulator
`timescale 1ns/1ps
`default_nettype none
module srx_modem_model
    import srx_pkg::*;
(
    input  wire logic     core_clk,
    output var srx_evt_s  evt
);
    initial evt = '0;
    // one event for one cycle; released byte lane shows inverted data
    task automatic pulse(input srx_evt_s e);
        @(posedge core_clk);
        evt <= e;
        @(posedge core_clk);
        evt <= '{byte_data: ~e.byte_data, default: '0};
    endtask
    // whole packet in legal order, gap+1 idle cycles between bytes
    task automatic pkt(input int n, input logic [7:0] b0, input logic bad, input int gap);
        pulse('{preamble_start: 1'b1, default: '0});
        pulse('{preamble_sync: 1'b1, default: '0});
        pulse('{header_ok: 1'b1, default: '0});
        for (int i = 0; i < n; i++)
        begin
            repeat (gap) @(posedge core_clk);
            pulse('{byte_valid: 1'b1, byte_data: b0 + 8'(i), default: '0});
        end
        pulse('{payload_done: 1'b1, crc_bad: bad, default: '0});
    endtask
    // symbol ticks
    task automatic ticks(input int n);
        repeat (n) pulse('{sym_tick: 1'b1, default: '0});
    endtask
    // preamble lasting n symbols, then a lock attempt
    task automatic longpre(input int n);
        pulse('{preamble_start: 1'b1, default: '0});
        ticks(n);
        pulse('{preamble_sync: 1'b1, default: '0});
    endtask
endmodule // srx_modem_model
`default_nettype wire

/* sim/tb_top.sv */
// testbench: register and packet scenarios for the receive mode control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import srx_pkg::*;
;
    logic        core_clk   = 1'b0;
    logic        rst_n      = 1'b0;
    logic        cyc        = 1'b0;
    logic        stb        = 1'b0;
    logic        we         = 1'b0;
    logic [7:0]  adr        = 8'h00;
    logic [3:0]  sel        = 4'hf;
    logic [31:0] dat        = 32'h0;
    logic [31:0] rd;
    logic [31:0] dat_o;
    logic        ack;
    logic        gain_freeze;
    logic        rx_active;
    logic [2:0]  mode;
    srx_evt_s    evt;
    int          n_errors   = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    // clock
    always #10 core_clk = ~core_clk;
    srx_rx_ctrl srx_rx_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .evt(evt), .gain_freeze(gain_freeze), .rx_active(rx_active), .mode_out(mode));
    srx_modem_model srx_modem_model_i (.core_clk(core_clk), .evt(evt));
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic conclude;
        if (n_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // classic wishbone cycle, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 40);
        if (ack !== 1'b1) n_errors++;
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        rdc("mode", OFS_MODE, 32'h1);
        rdc("symwin", OFS_SYMWIN, 32'h5);
        rdc("rxbase", OFS_RXBASE, 32'h0);
        rdc("prelen", OFS_PRELEN, 32'h8);
        rdc("unmapped", 8'h2c, 32'h0);
        sel <= 4'he;
        wr(OFS_SYMWIN, 32'h9);
        sel <= 4'hf;
        rdc("selgate", OFS_SYMWIN, 32'h5);
    endtask
    task automatic t_single;
        wr(OFS_PTR, 32'h0);
        wr(OFS_MODE, 32'h6);
        srx_modem_model_i.pkt(3, 8'h5a, 1'b1, 0);
        rdc("flags", OFS_FLAGS, 32'he);
        chk("mode", 32'(mode), 32'h1);
        chk("rxoff", {31'h0, rx_active}, 32'h0);
        rdc("nbytes", OFS_NBYTES, 32'h3);
        rdc("start", OFS_PKTSTRT, 32'h0);
        rdc("wrpos", OFS_WRPOS, 32'h3);
        for (int i = 0; i < 3; i++)
            rdc("byte", OFS_DATA, 32'h5a + i);
        rdc("ptr", OFS_PTR, 32'h3);
        wr(OFS_FLAGS, 32'hf);
        rdc("clear", OFS_FLAGS, 32'h0);
    endtask
    task automatic t_timeout;
        wr(OFS_SYMWIN, 32'h4);
        wr(OFS_MODE, 32'h6);
        srx_modem_model_i.ticks(3);
        rdc("early", OFS_FLAGS, 32'h0);
        chk("stay", 32'(mode), 32'h6);
        srx_modem_model_i.ticks(1);
        rdc("tmo", OFS_FLAGS, 32'h1);
        chk("standby", 32'(mode), 32'h1);
        rdc("sticky", OFS_FLAGS, 32'h1);
        wr(OFS_FLAGS, 32'h1);
    endtask
    task automatic t_cont;
        wr(OFS_TMO, 32'h14);
        wr(OFS_MODE, 32'h5);
        srx_modem_model_i.pkt(2, 8'h10, 1'b0, 0);
        rdc("flags", OFS_FLAGS, 32'ha);
        chk("cont", 32'(mode), 32'h5);
        chk("rxact", {31'h0, rx_active}, 32'h1);
        wr(OFS_FLAGS, 32'hf);
        srx_modem_model_i.pkt(2, 8'h20, 1'b0, 3);
        rdc("start", OFS_PKTSTRT, 32'h2);
        rdc("wrpos", OFS_WRPOS, 32'h4);
        rdc("count", OFS_NBYTES, 32'h2);
        wr(OFS_PTR, 32'h2);
        rdc("byte", OFS_DATA, 32'h20);
        rdc("byte2", OFS_DATA, 32'h21);
        wr(OFS_FLAGS, 32'hf);
        srx_modem_model_i.longpre(9);
        rdc("silent", OFS_FLAGS, 32'h0);
        chk("nolock", {31'h0, gain_freeze}, 32'h0);
        srx_modem_model_i.ticks(10);
        rdc("notyet", OFS_FLAGS, 32'h0);
        srx_modem_model_i.ticks(1);
        rdc("tmo", OFS_FLAGS, 32'h1);
        chk("stay", 32'(mode), 32'h5);
        wr(OFS_FLAGS, 32'h1);
        rdc("cleared", OFS_FLAGS, 32'h0);
        wr(OFS_MODE, 32'h0);
        rdc("sleep", OFS_DATA, 32'h0);
    endtask
    // main sequence
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_single();
        t_timeout();
        t_cont();
        conclude();
    end
    // hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            conclude();
        end
    end
endmodule // tb_top
`default_nettype wire
